// ===== rtl/sbs_array.sv
`timescale 1ns/10ps
`default_nettype none
// storage: writes on the edge, reads combinationally so data flows through
module sbs_array
    import sbs_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int LANES = LANES_DEF
) (
    input wire logic mclk,
    sbs_array_if.mem ary
);
    // ==========================================
    // storage
    // ==========================================
    // flow-through read trades output timing for zero latency
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            logic [LANE_W-1:0] bank_q [2**ADDR_W];  // one bank per lane, one writer each
            always_ff @(posedge mclk) begin
                if (ary.wr_lane[g]) begin
                    bank_q[ary.addr] <= ary.wdata[g*LANE_W +: LANE_W];
                end
            end
            assign ary.rdata[g*LANE_W +: LANE_W] = bank_q[ary.addr];
        end
    endgenerate
endmodule : sbs_array
`default_nettype wire

// ===== rtl/sbs_array_if.sv
`timescale 1ns/10ps
`default_nettype none
// array port between the controller and the storage
interface sbs_array_if #(parameter int ADDR_W = 19, parameter int LANES = 2, parameter int LANE_W = 9);
    logic [ADDR_W-1:0] addr;           // word address, combinational
    logic [LANES-1:0] wr_lane;         // lanes to write this cycle
    logic [LANES*LANE_W-1:0] wdata;    // write data
    logic [LANES*LANE_W-1:0] rdata;    // read data, flows through
    modport ctl (output addr, output wr_lane, output wdata, input rdata);
    modport mem (input addr, input wr_lane, input wdata, output rdata);
endinterface : sbs_array_if
`default_nettype wire

// ===== rtl/sbs_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - deselect cases float data, use no address
// - full select with processor strobe starts read
// - cache strobe start; write when write controls ask
// - both strobes high, advance low steps address
// - continuation writes; chip enable high ignores processor strobe
// - advance high holds current burst address
// - suspended write rewrites at unchanged address
// - global write all lanes, else selected lanes
// - any lane combination written together
// - third and fourth selects unused in x18
// - output enable gates read drive asynchronously
// - writes and deselect leave pins undriven
// - sleep input floats pins, ignores clocked operations
// - interleaved order xors start with count
// - linear order increments start modulo four
// - counter wraps after fourth word
// - only two low address bits advance
// - both strobes start reads identically
module sbs_ctrl
    import sbs_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int LANES = LANES_DEF
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic chip_en_n,
    input wire logic select_hi,
    input wire logic select_lo_n,
    input wire logic proc_addr_strobe_n,
    input wire logic cache_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic global_write_n,
    input wire logic byte_write_en_n,
    input wire logic byte_lane0_sel_n,
    input wire logic byte_lane1_sel_n,
    input wire logic byte_lane2_sel_n,
    input wire logic byte_lane3_sel_n,
    input wire logic out_en_n,
    input wire logic sleep_req,
    input wire logic burst_order_sel,
    input wire logic [LANES*LANE_W-1:0] data_in,
    output logic [LANES*LANE_W-1:0] data_out,
    output logic data_oe,
    output logic [1:0] power_state
);
    // ==========================================
    // elaboration checks
    // ==========================================
    // refused at elaboration, before any logic is built
    if (LANES < 1 || LANES > SEL_PINS) begin : g_bad_lanes
        $error("lane count must be 1 to 4");
    end
    if (ADDR_W <= BURST_W || ADDR_W > 24) begin : g_bad_addr
        $error("address width out of range");
    end

    // ==========================================
    // reset release
    // ==========================================
    logic rst_s1_ff;    // first release stage
    logic rst_s2_ff;    // synchronised reset, active low

    // release through two flops, assert at once
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end

    // ==========================================
    // sleep input crossing (asynchronous pin)
    // ==========================================
    logic zz_s1_ff;     // metastability stage, read only by zz_s2_ff
    logic zz_s2_ff;     // second stage
    logic zz_s3_ff;     // third stage
    logic sleep_ff;     // accepted level

    // a change counts once stages two and three agree
    always_ff @(posedge mclk or negedge rst_s2_ff) begin
        if (!rst_s2_ff) begin
            zz_s1_ff <= 1'b0;
            zz_s2_ff <= 1'b0;
            zz_s3_ff <= 1'b0;
            sleep_ff <= 1'b0;
        end else begin
            zz_s1_ff <= sleep_req;
            zz_s2_ff <= zz_s1_ff;
            zz_s3_ff <= zz_s2_ff;
            if (zz_s2_ff == zz_s3_ff) begin
                sleep_ff <= zz_s3_ff;
            end
        end
    end

    // pin level also floats outputs at once, the synced copy gates clocked work
    logic sleeping;
    assign sleeping = sleep_req || sleep_ff;

    // ==========================================
    // decode helpers
    // ==========================================
    // full select: chip enable low, active-high select high, active-low low
    function automatic logic sbs_selected(input logic ce_n, input logic s_hi, input logic s_lo_n);
        return !ce_n && s_hi && !s_lo_n;
    endfunction : sbs_selected

    // lanes to write; x18 ignores the upper two selects
    function automatic logic [LANES-1:0] sbs_lanes(input logic gw_n, input logic bwe_n,
                                                   input logic [SEL_PINS-1:0] sel_n);
        logic [LANES-1:0] res;
        res = '0;
        if (!gw_n) begin
            res = '1;
        end else if (!bwe_n) begin
            res = ~sel_n[LANES-1:0];
        end
        return res;
    endfunction : sbs_lanes

    // next burst offset from start value and count
    function automatic logic [BURST_W-1:0] sbs_offset(input logic inter, input logic [1:0] start,
                                                      input logic [1:0] cnt);
        return inter ? (start ^ cnt) : 2'(start + cnt);
    endfunction : sbs_offset

    // ==========================================
    // cycle decode
    // ==========================================
    logic [SEL_PINS-1:0] sel_n;     // byte selects as a bus
    logic [LANES-1:0] want_lanes;   // lanes requested this edge
    logic full_sel;                 // device fully selected
    sbs_op_t op;                    // operation for this edge
    logic op_write;                 // write requested this edge

    assign sel_n = {byte_lane3_sel_n, byte_lane2_sel_n, byte_lane1_sel_n, byte_lane0_sel_n};
    assign want_lanes = sbs_lanes(global_write_n, byte_write_en_n, sel_n);
    assign full_sel = sbs_selected(chip_en_n, select_hi, select_lo_n);

    // truth table priority: strobes first, then advance
    always_comb begin
        op = SBS_OP_HOLD;
        op_write = 1'b0;
        // only the synced copy may steer flops; the raw pin would go metastable
        if (sleep_ff) begin
            op = SBS_OP_IDLE;
        end else if (!cache_addr_strobe_n && chip_en_n) begin
            op = SBS_OP_DESEL;
        end else if (!chip_en_n && (!proc_addr_strobe_n || !cache_addr_strobe_n) && !full_sel) begin
            op = SBS_OP_DESEL;
        end else if (full_sel && !proc_addr_strobe_n) begin
            op = SBS_OP_START;  // read, write inputs ignored
        end else if (full_sel && !cache_addr_strobe_n) begin
            op = SBS_OP_START;
            op_write = |want_lanes;
        end else if (cache_addr_strobe_n && (proc_addr_strobe_n || chip_en_n)) begin
            // chip enable high masks the processor strobe
            op = burst_advance_n ? SBS_OP_HOLD : SBS_OP_NEXT;
            op_write = |want_lanes;
        end else begin
            op = SBS_OP_DESEL;  // not reached, every input case is decoded by the branches above
        end
    end

    // ==========================================
    // address and burst counter
    // ==========================================
    logic [ADDR_W-1:0] base_ff;     // loaded external address
    logic [1:0] cnt_ff;             // burst count 0..3
    logic order_ff;                 // burst order, static pin captured
    logic [1:0] nxt_cnt;            // count after this edge
    logic [ADDR_W-1:0] cur_addr;    // address used this cycle

    // order pin is static by contract, sampled every cycle
    always_ff @(posedge mclk or negedge rst_s2_ff) begin
        if (!rst_s2_ff) begin
            order_ff <= 1'b1;
        end else begin
            order_ff <= burst_order_sel;
        end
    end

    // two-bit count wraps by width
    always_comb begin
        nxt_cnt = cnt_ff;
        if (op == SBS_OP_NEXT) begin
            nxt_cnt = 2'(cnt_ff + BURST_ONE);
        end
    end

    // load on start, step the count on advance, hold otherwise; upper bits never move
    always_ff @(posedge mclk or negedge rst_s2_ff) begin
        if (!rst_s2_ff) begin
            base_ff <= '0;
            cnt_ff <= BURST_ZERO;
        end else if (op == SBS_OP_START) begin
            base_ff <= addr;
            cnt_ff <= BURST_ZERO;
        end else if (op != SBS_OP_IDLE && op != SBS_OP_DESEL) begin
            cnt_ff <= nxt_cnt;
        end
    end

    // ==========================================
    // cycle state registered at the edge
    // ==========================================
    logic active_ff;    // a burst word is being accessed
    logic write_ff;     // that access is a write
    logic [LANES-1:0] lanes_ff;  // lanes latched for the self-timed write
    logic [LANES*LANE_W-1:0] wdata_ff;  // data latched with the write

    // form the address: loaded base upper bits, counter offset on the low two
    always_comb begin
        cur_addr = {base_ff[ADDR_W-1:BURST_W],
                    sbs_offset(order_ff, base_ff[BURST_W-1:0], cnt_ff)};
    end

    // deselect and sleep clear the access, so pins float
    always_ff @(posedge mclk or negedge rst_s2_ff) begin
        if (!rst_s2_ff) begin
            active_ff <= 1'b0;
            write_ff <= 1'b0;
            lanes_ff <= '0;
            wdata_ff <= '0;
        end else begin
            active_ff <= (op != SBS_OP_DESEL) && (op != SBS_OP_IDLE);
            write_ff <= op_write;
            lanes_ff <= op_write ? want_lanes : '0;
            wdata_ff <= data_in;
        end
    end

    // ==========================================
    // storage
    // ==========================================
    sbs_array_if #(.ADDR_W(ADDR_W), .LANES(LANES), .LANE_W(LANE_W)) ary ();

    // write after the address for that cycle is formed, lanes together
    logic [ADDR_W-1:0] eff_addr;
    assign eff_addr = cur_addr;
    assign ary.addr = eff_addr;
    // a write taken while awake completes; gating it on the raw pin would be unsafe
    assign ary.wr_lane = (active_ff && write_ff) ? lanes_ff : '0;
    assign ary.wdata = wdata_ff;

    sbs_array #(.ADDR_W(ADDR_W), .LANES(LANES)) u_array (
        .mclk(mclk),
        .ary(ary)
    );

    // ==========================================
    // data pins
    // ==========================================
    // flow-through: array word follows the captured address
    assign data_out = ary.rdata;

    // drive only on an active read with enable low, no clock involved
    assign data_oe = active_ff && !write_ff && !out_en_n && !sleeping;

    // ==========================================
    // power state
    // ==========================================
    always_comb begin
        if (sleeping) begin
            power_state = SBS_PWR_SLEEP;
        end else if (!active_ff) begin
            power_state = SBS_PWR_STANDBY;
        end else begin
            power_state = SBS_PWR_ACTIVE;
        end
    end
endmodule : sbs_ctrl
`default_nettype wire

// ===== rtl/sbs_pkg.sv
package sbs_pkg;
    // ==========================================
    // organisation
    // ==========================================
    localparam int ADDR_W_DEF = 19;       // address bits, 512k x 18 organisation
    localparam int LANES_DEF = 2;         // byte lanes that really exist in x18
    localparam int LANE_W = 9;            // eight data bits plus parity per lane
    localparam int SEL_PINS = 4;          // byte select pins on the package
    localparam int BURST_W = 2;           // counter covers the two low address bits
    localparam logic [1:0] BURST_ZERO = 2'h0;
    localparam logic [1:0] BURST_ONE = 2'h1;
    // ==========================================
    // timing
    // ==========================================
    localparam int CLK_PERIOD_NS = 100;   // mclk period
    localparam int SLEEP_PW_NS = 100;     // least sleep pulse, far side keeps it
    localparam int SLEEP_REC_NS = 100;    // least recovery after sleep, far side
    localparam int SLEEP_REC_CYC = (SLEEP_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ==========================================
    // clocked operations
    // ==========================================
    typedef enum logic [2:0] {
        SBS_OP_DESEL = 3'h0,  // deselect, standby
        SBS_OP_START = 3'h1,  // load external address
        SBS_OP_NEXT = 3'h2,   // advance burst counter
        SBS_OP_HOLD = 3'h3,   // suspend at current address
        SBS_OP_IDLE = 3'h4    // sleep, nothing clocked
    } sbs_op_t;
    typedef enum logic [1:0] {
        SBS_PWR_ACTIVE = 2'h0,
        SBS_PWR_STANDBY = 2'h1,
        SBS_PWR_SLEEP = 2'h2
    } sbs_pwr_t;
endpackage : sbs_pkg

// ===== test/sbs_bus_host.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// controller model on the far side of the bus
// ==========================================
module sbs_bus_host
    import sbs_pkg::*;
(
    input wire logic mclk,
    output var logic [ADDR_W_DEF-1:0] addr,
    output var logic [5:0] ctl, // enable, selects, both strobes, advance
    output var logic [5:0] wr, // global, byte enable, lane selects 3..0
    output var logic out_en_n,
    output var logic sleep_req,
    output var logic burst_order_sel,
    output var logic [LANES_DEF*LANE_W-1:0] data_in
);
    // power up deselected, order fixed from the start
    initial begin
        addr = 19'h0;
        ctl = 6'h35;
        wr = 6'h3f;
        out_en_n = 1'h0;
        sleep_req = 1'h0;
        burst_order_sel = 1'h1;
        data_in = 18'h0;
    end
    // one bus cycle, held until the edge that takes it
    task automatic cyc(input logic [5:0] k, input logic [5:0] w, input logic [18:0] a,
                       input logic [17:0] d);
        ctl = k;
        wr = w;
        addr = a;
        // an idle data bus shows no stale word
        data_in = (!w[5] || (!w[4] && w[1:0] != 2'h3)) ? d : ~data_in;
        @(posedge mclk);
        #1;
    endtask : cyc
    // order only moves while the device is held in reset
    task automatic cfg(input logic o, input logic oen);
        burst_order_sel = o;
        out_en_n = oen;
    endtask : cfg
    task automatic doze();
        sleep_req = 1'h1;
    endtask : doze
    // leave sleep deselected and wait out recovery
    task automatic wake(input logic [18:0] a);
        cyc(6'h35, 6'h3f, a, data_in);
        sleep_req = 1'h0;
        // recovery plus three edges, the four the device's sleep synchroniser takes
        repeat (SLEEP_REC_CYC + 3) cyc(6'h35, 6'h3f, a, data_in);
    endtask : wake
endmodule : sbs_bus_host
`default_nettype wire

// ===== test/sbs_ctrl_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// port checker for the burst controller
// ==========================================
module sbs_ctrl_asserts
    import sbs_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int LANES = LANES_DEF
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic chip_en_n,
    input wire logic select_hi,
    input wire logic select_lo_n,
    input wire logic proc_addr_strobe_n,
    input wire logic cache_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic global_write_n,
    input wire logic byte_write_en_n,
    input wire logic byte_lane0_sel_n,
    input wire logic byte_lane1_sel_n,
    input wire logic out_en_n,
    input wire logic sleep_req,
    input wire logic [LANES*LANE_W-1:0] data_out,
    input wire logic data_oe,
    input wire logic [1:0] power_state
);
    logic [2:0] live_ff; // edges since reset, internal copy lags the pin
    logic [3:0] zz_ff; // recent sleep history, covers the synced sleep path
    logic ok, full, wr_ctl, cont, desel, p_start, c_start;
    // settle window after reset
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) live_ff <= 3'h0;
        else live_ff <= {live_ff[1:0], 1'h1};
    end
    // sleep history, reset pessimistic so nothing is judged too early
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) zz_ff <= 4'hf;
        else zz_ff <= {zz_ff[2:0], sleep_req};
    end
    assign ok = live_ff[2] && !sleep_req && zz_ff == 4'h0;
    assign full = !chip_en_n && select_hi && !select_lo_n;
    assign wr_ctl = !global_write_n || (!byte_write_en_n && !(byte_lane0_sel_n && byte_lane1_sel_n));
    assign cont = cache_addr_strobe_n && (proc_addr_strobe_n || chip_en_n);
    assign p_start = full && !proc_addr_strobe_n;
    assign c_start = full && proc_addr_strobe_n && !cache_addr_strobe_n;
    assign desel = !cont && !p_start && !c_start;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // ==========================================
    // sequences and properties
    // ==========================================
    sequence s_rd_take;
        ok && (p_start || ((c_start || cont) && !wr_ctl));
    endsequence
    sequence s_hold_rd;
        ok && cont && burst_advance_n && !wr_ctl;
    endsequence
    a_desel_float: assert property (ok && desel |=> sleep_req ||
        (!data_oe && power_state == SBS_PWR_STANDBY)) else $error("deselect left pins driven");
    a_proc_read: assert property (ok && p_start |=> sleep_req ||
        (data_oe == !out_en_n && power_state == SBS_PWR_ACTIVE)) else $error("read start wrong");
    a_cache_write: assert property (ok && c_start && wr_ctl |=> !data_oe)
        else $error("write start drove pins");
    a_cache_read: assert property (ok && c_start && global_write_n && byte_write_en_n
        |=> sleep_req || data_oe == !out_en_n) else $error("cache read start wrong");
    a_lane_hi_ignored: assert property (ok && c_start && global_write_n
        && !byte_write_en_n && byte_lane0_sel_n && byte_lane1_sel_n |=> sleep_req ||
        data_oe == !out_en_n) else $error("upper selects acted");
    a_cont_write: assert property (ok && cont && wr_ctl |=> !data_oe &&
        (sleep_req || power_state == SBS_PWR_ACTIVE)) else $error("burst write drove pins");
    a_hold_repeat: assert property (s_rd_take ##1 s_hold_rd |=>
        sleep_req || data_out == $past(data_out)) else $error("suspended read moved");
    a_oe_gates: assert property (out_en_n |-> !data_oe)
        else $error("pins driven with output enable high");
    a_sleep_float: assert property ((live_ff[2] && sleep_req) [*3] |-> !data_oe &&
        power_state == SBS_PWR_SLEEP) else $error("sleep not entered");
endmodule : sbs_ctrl_asserts
bind sbs_ctrl sbs_ctrl_asserts #(.ADDR_W(ADDR_W), .LANES(LANES)) sbs_ctrl_asserts_inst (
    .mclk(mclk), .rst_b(rst_b), .chip_en_n(chip_en_n), .select_hi(select_hi),
    .select_lo_n(select_lo_n), .proc_addr_strobe_n(proc_addr_strobe_n),
    .cache_addr_strobe_n(cache_addr_strobe_n), .burst_advance_n(burst_advance_n),
    .global_write_n(global_write_n), .byte_write_en_n(byte_write_en_n),
    .byte_lane0_sel_n(byte_lane0_sel_n), .byte_lane1_sel_n(byte_lane1_sel_n),
    .out_en_n(out_en_n), .sleep_req(sleep_req), .data_out(data_out), .data_oe(data_oe),
    .power_state(power_state));
`default_nettype wire

// ===== test/tb.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// bench: reference decode plus scenarios
// ==========================================
module tb
    import sbs_pkg::*;
;
    logic mclk = 1'h0;
    logic rst_b = 1'h0;
    logic [18:0] addr, base, cur;
    logic [5:0] ctl, wr;
    logic out_en_n, sleep_req, order, data_oe;
    logic [17:0] data_in, data_out;
    logic [1:0] power_state, cnt;
    logic [17:0] mem [bit [18:0]]; // shadow of words written so far
    int n_mismatch = 0;
    int n_checks = 0;
    int n_cyc = 0;
    always #(CLK_PERIOD_NS / 2) mclk = ~mclk;
    sbs_bus_host sbs_bus_host_inst (.mclk(mclk), .addr(addr), .ctl(ctl), .wr(wr),
        .out_en_n(out_en_n), .sleep_req(sleep_req), .burst_order_sel(order), .data_in(data_in));
    sbs_ctrl sbs_ctrl_inst (.mclk(mclk), .rst_b(rst_b), .addr(addr), .chip_en_n(ctl[5]),
        .select_hi(ctl[4]), .select_lo_n(ctl[3]), .proc_addr_strobe_n(ctl[2]),
        .cache_addr_strobe_n(ctl[1]), .burst_advance_n(ctl[0]), .global_write_n(wr[5]),
        .byte_write_en_n(wr[4]), .byte_lane3_sel_n(wr[3]), .byte_lane2_sel_n(wr[2]),
        .byte_lane1_sel_n(wr[1]), .byte_lane0_sel_n(wr[0]), .out_en_n(out_en_n),
        .sleep_req(sleep_req), .burst_order_sel(order), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .power_state(power_state));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict
    // hang guard, the run needs about 80 cycles
    always @(posedge mclk) begin
        n_cyc++;
        if (n_cyc == 3000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic do_reset(input logic o);
        rst_b = 1'h0;
        mem.delete();
        sbs_bus_host_inst.cfg(o, 1'h0);
        repeat (2) @(posedge mclk);
        #1;
        rst_b = 1'h1;
        repeat (3) sbs_bus_host_inst.cyc(6'h35, 6'h3f, 19'h0, 18'h0);
        chk("standby", power_state, SBS_PWR_STANDBY);
    endtask : do_reset
    // drive one cycle and judge it against the decode worked out here
    task automatic step(input logic [5:0] k, input logic [5:0] w, input logic [18:0] a,
                        input logic [17:0] d);
        logic act, wrt, rd;
        logic [17:0] m;
        act = 1'h1;
        wrt = !w[5] || (!w[4] && w[1:0] != 2'h3);
        if (!k[5] && (!k[2] || !k[1])) begin
            if (k[4] && !k[3]) begin
                base = a;
                cnt = 2'h0;
                wrt = wrt && k[2];
            end else act = 1'h0;
        end else if (!k[1]) act = 1'h0;
        else if (!k[0]) cnt = cnt + 2'h1;
        cur = {base[18:2], order ? base[1:0] ^ cnt : base[1:0] + cnt};
        rd = act && !wrt;
        sbs_bus_host_inst.cyc(k, w, a, d);
        chk("drive", data_oe, rd && !out_en_n);
        chk("power", power_state, act ? SBS_PWR_ACTIVE : SBS_PWR_STANDBY);
        if (rd && mem.exists(cur)) chk("word", data_out, mem[cur]);
        if (act && wrt) begin
            m = mem.exists(cur) ? mem[cur] : 18'h0;
            if (!w[5] || !w[0]) m[8:0] = d[8:0];
            if (!w[5] || !w[1]) m[17:9] = d[17:9];
            mem[cur] = m;
        end
    endtask : step
    // write a burst, read it back past the wrap
    task automatic t_burst(input logic [18:0] a);
        for (int i = 0; i < 4; i++) begin
            step(i == 0 ? 6'h15 : 6'h16, 6'h1f, a, 18'(i * 18'h1357 + 18'h0a5));
        end
        step(6'h13, 6'h1f, a, 18'h0);
        for (int i = 0; i < 5; i++) step(6'h16, 6'h3f, a, 18'h0);
    endtask : t_burst
    task automatic t_bytes(input logic [18:0] a);
        step(6'h15, 6'h1f, a, 18'h3ffff);
        for (int p = 0; p < 4; p++) begin
            step(6'h15, {4'h8, 2'(p)}, a, 18'h0f0f0 + 18'(p));
            step(6'h15, 6'h3f, a, 18'h0);
        end
        step(6'h15, 6'h30, a, 18'h0);
    endtask : t_bytes
    task automatic t_hold(input logic [18:0] a);
        step(6'h15, 6'h1f, a, 18'h11111);
        step(6'h17, 6'h1f, a, 18'h22222);
        step(6'h16, 6'h1f, a, 18'h33333);
        step(6'h13, 6'h3f, a, 18'h0);
        repeat (2) step(6'h17, 6'h3f, a, 18'h0);
        step(6'h32, 6'h3f, a, 18'h0);
    endtask : t_hold
    task automatic t_desel(input logic [18:0] a);
        logic [5:0] ds [5] = '{6'h35, 6'h1b, 6'h03, 6'h1d, 6'h05};
        foreach (ds[i]) begin
            step(6'h13, 6'h3f, a, 18'h0);
            step(ds[i], 6'h1f, a ^ 19'h1, 18'h2aaaa);
        end
        // neighbour holds a burst word, so a write that landed would show here
        step(6'h13, 6'h3f, a ^ 19'h1, 18'h0);
    endtask : t_desel
    task automatic t_oe(input logic [18:0] a);
        sbs_bus_host_inst.cfg(order, 1'h1);
        step(6'h13, 6'h3f, a, 18'h0);
        #20;
        sbs_bus_host_inst.cfg(order, 1'h0);
        #1;
        chk("drive async", data_oe, 1'h1);
        @(posedge mclk);
        #1;
        step(6'h15, 6'h1f, a, 18'h155aa);
    endtask : t_oe
    task automatic t_sleep(input logic [18:0] a);
        step(6'h15, 6'h1f, a, 18'h0c0c0);
        sbs_bus_host_inst.doze();
        // the synced sleep needs four edges before a write is refused
        repeat (4) sbs_bus_host_inst.cyc(6'h35, 6'h3f, a, 18'h0);
        sbs_bus_host_inst.cyc(6'h15, 6'h1f, a, 18'h3f3f3);
        chk("sleep power", power_state, SBS_PWR_SLEEP);
        chk("sleep drive", data_oe, 1'h0);
        sbs_bus_host_inst.wake(a);
        step(6'h15, 6'h3f, a, 18'h0);
    endtask : t_sleep
    initial begin
        do_reset(1'h1);
        t_burst(19'h5a5a6);
        t_bytes(19'h01234);
        t_hold(19'h3c3c0);
        t_desel(19'h5a5a6);
        t_oe(19'h5a5a6);
        t_sleep(19'h01234);
        do_reset(1'h0);
        t_burst(19'h2d3b7);
        t_hold(19'h3c3c3);
        print_verdict();
    end
endmodule : tb
`default_nettype wire
